// ---- design/rdpm_top.sv ----
/*
 * rdpm_top: pin function selection for the reset/port pin, the debug/mode
 * pin, the port A general pins and the timer channel pins; includes a
 * small transmitter for one debug bit on the single-wire link.
 * Assumes: i_rst comes from the chip's reset generator (power-on or the
 * reset pin, after its own filtering); pad inputs are asynchronous.
 */
// Behaviour
// - after power-on reset the shared reset pin comes up as port_a_bit5 input.
// - setting reset_pin_enable makes the pin the active-low reset input.
// - once the reset function is on it stays on until the next reset.
// - a low level on the pin in reset role requests a whole-chip reset.
// - while reset_pin_enable is 1 the pin pullup is on.
// - during reset the debug pin is the mode-select strap and is sampled.
// - right after reset the debug pin becomes the debug line.
// - in strap or debug role the debug pin pullup is on.
// - clearing debug_pin_enable turns the debug pin into an output port.
// - a high strap at reset release selects normal run mode.
// - a low strap through reset selects active background mode.
// - each debug bit lasts 16 debug controller clocks.
// - the debug controller clock equals the bus clock.
// - the line is pseudo open drain with a brief driven-high speedup pulse.
// - after reset the other pins are inputs with pulls off.
// - timer channels 0 and 1 can be remapped onto port_a_bit0 and bit1.
`default_nettype none
module rdpm_top
    import rdpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_rstpin_in,
    output logic o_rstpin_pullup,
    output logic o_ext_reset_req,
    output logic o_port_a_bit5,
    input wire logic i_dbg_in,
    output logic o_dbg_out,
    output logic o_dbg_oe,
    output logic o_dbg_pullup,
    input wire logic i_port_a_bit4_data,
    output logic o_background_mode,
    input wire logic [NPINS-1:0] i_port_dout,
    input wire logic [NPINS-1:0] i_port_dir,
    input wire logic [NPINS-1:0] i_port_pull,
    input wire logic i_tmr_ch0_out,
    input wire logic i_tmr_ch0_oe,
    input wire logic i_tmr_ch1_out,
    input wire logic i_tmr_ch1_oe,
    output logic [NPINS-1:0] o_pin_out,
    output logic [NPINS-1:0] o_pin_oe,
    output logic [NPINS-1:0] o_pin_pull
);
    // pins 0..3 are port A bits 0..3, pins 4 and 5 are the default
    // timer channel pins on port B
    logic [7:0] sysopt_q, sysopt_d;
    logic [7:0] pinsel_q, pinsel_d;
    logic rst_lock_q, rst_lock_d;
    logic strap_seen_q, strap_seen_d;
    logic bgnd_q, bgnd_d;
    logic [7:0] rdata_q, rdata_d;
    logic rs1_q, rs2_q, ds1_q, ds2_q;
    logic ext_req_q, ext_req_d;
    logic p5_q, p5_d;
    logic [NPINS-1:0] out_q, out_d, oe_q, oe_d, pull_q, pull_d;
    logic rpu_q, rpu_d, dpu_q, dpu_d, dout_q, dout_d, doe_q, doe_d;
    rdpm_dbg_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic txbit_q, txbit_d;
    logic [4:0] busy_len_q, busy_len_d;

    function automatic logic dbg_role(input logic [7:0] opt);
        dbg_role = opt[SYSOPT_DBGPIN_BIT];
    endfunction : dbg_role

    // synchronise pad levels before any logic looks at them
    always_ff @(posedge i_ref_clk) begin
        rs1_q <= i_rstpin_in;
        rs2_q <= rs1_q;
        ds1_q <= i_dbg_in;
        ds2_q <= ds1_q;
    end

    always_comb begin
        sysopt_d = sysopt_q;
        pinsel_d = pinsel_q;
        rst_lock_d = rst_lock_q;
        if (i_wr && i_addr == ADDR_SYSOPT) begin
            sysopt_d = i_wdata;
            // the reset role cannot be cleared by software
            sysopt_d[SYSOPT_RSTPIN_BIT] = i_wdata[SYSOPT_RSTPIN_BIT]
                                          | rst_lock_q;
            if (i_wdata[SYSOPT_RSTPIN_BIT])
                rst_lock_d = 1'b1;
        end else if (i_wr && i_addr == ADDR_PINSEL) begin
            pinsel_d = i_wdata;
        end
        rdata_d = 8'h00;
        if (i_rd) begin
            if (i_addr == ADDR_SYSOPT)
                rdata_d = sysopt_q;
            else if (i_addr == ADDR_PINSEL)
                rdata_d = pinsel_q;
            else if (i_addr == ADDR_STATUS)
                rdata_d = {4'h0, txbit_q, rs2_q, bgnd_q, rst_lock_q};
            else
                rdata_d = {6'h00, st_q};
        end
    end

    // strap capture: the strap level is held while reset is active, and
    // the first edge after release latches the mode
    always_comb begin
        strap_seen_d = strap_seen_q;
        bgnd_d = bgnd_q;
        if (!strap_seen_q) begin
            strap_seen_d = 1'b1;
            bgnd_d = ~ds2_q;
        end
    end

    // debug bit transmitter: one bit every 16 bus clocks
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        txbit_d = txbit_q;
        case (st_q)
            RDPM_DBG_IDLE: begin
                if (i_wr && i_addr == ADDR_DBGTX && dbg_role(sysopt_q)) begin
                    txbit_d = i_wdata[0];
                    cnt_d = 4'h0;
                    st_d = RDPM_DBG_LOW;
                end
            end
            RDPM_DBG_LOW: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == (txbit_q ? DBG_ONE_LOW_LAST
                                      : DBG_ZERO_LOW_LAST))
                    st_d = RDPM_DBG_SPEEDUP;
            end
            RDPM_DBG_SPEEDUP: begin
                cnt_d = cnt_q + 4'h1;
                st_d = RDPM_DBG_REST;
            end
            RDPM_DBG_REST: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == DBG_CNT_LAST)
                    st_d = RDPM_DBG_IDLE;
            end
            default: st_d = RDPM_DBG_IDLE;
        endcase
    end

    // busy-cycle count for the bit length checks only; drives no pin
    always_comb begin
        busy_len_d = 5'h00;
        if (st_q != RDPM_DBG_IDLE)
            busy_len_d = busy_len_q + 5'h01;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst)
            busy_len_q <= 5'h00;
        else
            busy_len_q <= busy_len_d;
    end

    // pin ownership, highest priority alternate first
    always_comb begin
        ext_req_d = rst_lock_q & ~rs2_q;
        p5_d = rst_lock_q ? 1'b0 : rs2_q;
        rpu_d = sysopt_q[SYSOPT_RSTPIN_BIT];
        if (i_rst || !strap_seen_q || dbg_role(sysopt_q)) begin
            dpu_d = 1'b1;
            dout_d = 1'b0;
            doe_d = 1'b0;
            if (!i_rst && strap_seen_q) begin
                doe_d = (st_q == RDPM_DBG_LOW)
                        || (st_q == RDPM_DBG_SPEEDUP);
                dout_d = (st_q == RDPM_DBG_SPEEDUP);
            end
        end else begin
            dpu_d = 1'b0;
            dout_d = i_port_a_bit4_data;
            doe_d = 1'b1;
        end
        out_d = i_port_dout;
        oe_d = i_port_dir;
        pull_d = i_port_pull & ~i_port_dir;
        if (pinsel_q[PINSEL_TMRMAP_BIT]) begin
            out_d[0] = i_tmr_ch0_oe ? i_tmr_ch0_out : i_port_dout[0];
            oe_d[0] = i_tmr_ch0_oe | i_port_dir[0];
            out_d[1] = i_tmr_ch1_oe ? i_tmr_ch1_out : i_port_dout[1];
            oe_d[1] = i_tmr_ch1_oe | i_port_dir[1];
        end else begin
            out_d[4] = i_tmr_ch0_oe ? i_tmr_ch0_out : i_port_dout[4];
            oe_d[4] = i_tmr_ch0_oe | i_port_dir[4];
            out_d[5] = i_tmr_ch1_oe ? i_tmr_ch1_out : i_port_dout[5];
            oe_d[5] = i_tmr_ch1_oe | i_port_dir[5];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sysopt_q <= SYSOPT_RESET;
            pinsel_q <= PINSEL_RESET;
            rst_lock_q <= 1'b0;
            strap_seen_q <= 1'b0;
            bgnd_q <= 1'b0;
            rdata_q <= 8'h00;
            ext_req_q <= 1'b0;
            p5_q <= 1'b0;
            out_q <= '0;
            oe_q <= '0;
            pull_q <= '0;
            rpu_q <= 1'b0;
            dpu_q <= 1'b1;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
            st_q <= RDPM_DBG_IDLE;
            cnt_q <= 4'h0;
            txbit_q <= 1'b0;
        end else begin
            sysopt_q <= sysopt_d;
            pinsel_q <= pinsel_d;
            rst_lock_q <= rst_lock_d;
            strap_seen_q <= strap_seen_d;
            bgnd_q <= bgnd_d;
            rdata_q <= rdata_d;
            ext_req_q <= ext_req_d;
            p5_q <= p5_d;
            out_q <= out_d;
            oe_q <= oe_d;
            pull_q <= pull_d;
            rpu_q <= rpu_d;
            dpu_q <= dpu_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            txbit_q <= txbit_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rstpin_pullup = rpu_q;
    assign o_ext_reset_req = ext_req_q;
    assign o_port_a_bit5 = p5_q;
    assign o_dbg_out = dout_q;
    assign o_dbg_oe = doe_q;
    assign o_dbg_pullup = dpu_q;
    assign o_background_mode = bgnd_q;
    assign o_pin_out = out_q;
    assign o_pin_oe = oe_q;
    assign o_pin_pull = pull_q;

    // every check runs on the bus clock and sleeps through reset, except
    // the two that look at what reset itself must set up
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    lock_sticky_a: assert property (
        rst_lock_q |=> rst_lock_q)
        else $error("reset role dropped");
    lock_bit_a: assert property (
        rst_lock_q |-> sysopt_q[SYSOPT_RSTPIN_BIT])
        else $error("option bit cleared under lock");
    rst_pullup_a: assert property (
        sysopt_q[SYSOPT_RSTPIN_BIT] |=> o_rstpin_pullup)
        else $error("reset pin pullup off");
    ext_req_a: assert property (
        (rst_lock_q && !rs2_q) |=> o_ext_reset_req)
        else $error("pin low did not request reset");
    port5_a: assert property (
        o_ext_reset_req |-> !o_port_a_bit5)
        else $error("port bit alive in reset role");
    dbg_pull_a: assert property (
        (strap_seen_q && dbg_role(sysopt_q)) |=> o_dbg_pullup)
        else $error("debug pullup off");
    dbg_port_a: assert property (
        (strap_seen_q && !dbg_role(sysopt_q)) |=> o_dbg_oe)
        else $error("output port not driven");
    bit_len_a: assert property (
        (st_q == RDPM_DBG_IDLE && st_d == RDPM_DBG_LOW)
        |=> (st_q != RDPM_DBG_IDLE) ##15 (st_q == RDPM_DBG_REST)
        ##1 (st_q == RDPM_DBG_IDLE))
        else $error("debug bit length wrong");
    busy_max_a: assert property (
        (st_q != RDPM_DBG_IDLE) |-> (busy_len_q < 5'(DBG_BIT_CYCLES)))
        else $error("debug bit overran its slot");
    speedup_a: assert property (
        (st_q == RDPM_DBG_SPEEDUP) |=> (o_dbg_oe && o_dbg_out))
        else $error("speedup pulse missing");
    remap_a: assert property (
        (pinsel_q[PINSEL_TMRMAP_BIT] && i_tmr_ch0_oe) |=> o_pin_oe[0])
        else $error("timer remap failed");
    strap_pull_a: assert property (
        disable iff (1'b0)
        i_rst |=> (o_dbg_pullup && !o_dbg_oe))
        else $error("strap pin not released with pullup");
    pads_off_a: assert property (
        disable iff (1'b0)
        i_rst |=> (o_pin_oe == 8'h00 && o_pin_pull == 8'h00))
        else $error("general pins not idle in reset");
    cv_lock_c: cover property (@(posedge i_ref_clk) rst_lock_q);
    cv_bgnd_c: cover property (@(posedge i_ref_clk) bgnd_q);
    cv_bit_c: cover property (@(posedge i_ref_clk)
        st_q == RDPM_DBG_SPEEDUP);
    cv_remap_c: cover property (@(posedge i_ref_clk)
        pinsel_q[PINSEL_TMRMAP_BIT]);
    cv_port_c: cover property (strap_seen_q && !dbg_role(sysopt_q));
endmodule : rdpm_top
`default_nettype wire

// ---- shared/rdpm_pkg.sv ----
/*
 * rdpm_pkg: constants for the reset/debug pin mux block.
 * Assumes a single 25 MHz bus clock and a plain register port.
 */
`default_nettype none
package rdpm_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam logic [1:0] ADDR_SYSOPT = 2'h0;
    localparam logic [1:0] ADDR_PINSEL = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam logic [1:0] ADDR_DBGTX = 2'h3;
    localparam int SYSOPT_RSTPIN_BIT = 0;
    localparam int SYSOPT_DBGPIN_BIT = 1;
    localparam logic [7:0] SYSOPT_RESET = 8'h02;
    localparam int PINSEL_TMRMAP_BIT = 0;
    localparam logic [7:0] PINSEL_RESET = 8'h00;
    localparam int unsigned DBG_BIT_CYCLES = 16;
    localparam int unsigned DBG_SPEEDUP_CYCLES = 1;
    localparam logic [3:0] DBG_CNT_LAST = 4'hF;
    // last count of the driven-low phase for a one bit and for a zero bit
    localparam logic [3:0] DBG_ONE_LOW_LAST = 4'h3;
    localparam logic [3:0] DBG_ZERO_LOW_LAST = 4'hC;
    localparam int NPINS = 8;
    typedef enum logic [1:0] {
        RDPM_DBG_IDLE = 2'b00,
        RDPM_DBG_LOW = 2'b01,
        RDPM_DBG_SPEEDUP = 2'b10,
        RDPM_DBG_REST = 2'b11
    } rdpm_dbg_state_t;
endpackage : rdpm_pkg
`default_nettype wire

// ---- bench/rdpm_pod.sv ----
/* rdpm_pod: debug pod and board reset source at the far side of the pins.
   Assumes the bench tells it when to hold the strap and drive reset. */
`default_nettype none
module rdpm_pod (
    input wire logic i_ref_clk,
    input wire logic i_hold_low,
    input wire logic i_rst_drive,
    input wire logic i_rst_val,
    input wire logic i_dbg_out,
    input wire logic i_dbg_oe,
    input wire logic i_dbg_pullup,
    input wire logic i_rst_pullup,
    output logic o_dbg_wire,
    output logic o_rst_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_q = 1'b0;
    // an undriven, unpulled line wanders, so a missing pullup shows up
    always @(posedge i_ref_clk) float_q <= ~float_q;
    // pod holds the strap low while i_hold_low is set, otherwise lets go
    assign o_dbg_wire = i_dbg_oe ? i_dbg_out : i_hold_low ? 1'b0 :
                        i_dbg_pullup ? 1'b1 : float_q;
    // board source pulls the pin only while asked
    assign o_rst_wire = i_rst_drive ? i_rst_val :
                        i_rst_pullup ? 1'b1 : float_q;
endmodule : rdpm_pod
`default_nettype wire

// ---- bench/reset_debug_pin_mux_tb.sv ----
/* reset_debug_pin_mux_tb: self-checking bench for rdpm_top.
   Assumes rdpm_pod stands for the debug pod and the reset source. */
`default_nettype none
module reset_debug_pin_mux_tb import rdpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, rd_seen, hold, rdrv, rval, pa4;
    logic rst_wire, rpu, ext_req, pa5, dbg_wire, dout, doe, dpu, bg;
    logic t0o, t0e, t1o, t1e;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, pdout, pdir, ppull, pout, poe, ppl;
    logic [7:0] expq[$];
    int num_errors = 0;
    int n_checks = 0;
    rdpm_top rdpm_top_inst (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_rstpin_in(rst_wire), .o_rstpin_pullup(rpu),
        .o_ext_reset_req(ext_req), .o_port_a_bit5(pa5), .i_dbg_in(dbg_wire),
        .o_dbg_out(dout), .o_dbg_oe(doe), .o_dbg_pullup(dpu),
        .i_port_a_bit4_data(pa4), .o_background_mode(bg),
        .i_port_dout(pdout), .i_port_dir(pdir), .i_port_pull(ppull),
        .i_tmr_ch0_out(t0o), .i_tmr_ch0_oe(t0e), .i_tmr_ch1_out(t1o),
        .i_tmr_ch1_oe(t1e), .o_pin_out(pout), .o_pin_oe(poe),
        .o_pin_pull(ppl));
    rdpm_pod rdpm_pod_inst (.i_ref_clk(clk), .i_hold_low(hold),
        .i_rst_drive(rdrv), .i_rst_val(rval), .i_dbg_out(dout),
        .i_dbg_oe(doe), .i_dbg_pullup(dpu), .i_rst_pullup(rpu),
        .o_dbg_wire(dbg_wire), .o_rst_wire(rst_wire));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wait_n
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    task automatic do_reset(input logic strap_low);
        @(posedge clk);
        hold <= strap_low;
        rst <= 1'b1;
        // three edges so the strap synchroniser is full
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        hold <= 1'b0;
        wait_n(2);
    endtask : do_reset
    task automatic send_bit(input logic b, input int lows);
        int nl;
        int ns;
        nl = 0;
        ns = 0;
        wr_reg(ADDR_DBGTX, {7'h00, b});
        repeat (24) begin
            @(negedge clk);
            if (doe === 1'b1 && dout === 1'b0) nl++;
            if (doe === 1'b1 && dout === 1'b1) ns++;
        end
        chk(8'(nl), 8'(lows));
        chk(8'(ns), 8'(DBG_SPEEDUP_CYCLES));
    endtask : send_bit
    always @(posedge clk) rd_seen <= rd;
    // read data stand only in the cycle after the strobe
    always @(negedge clk) if (rd_seen === 1'b1) begin
        if (expq.size() == 0) chk(8'hEE, 8'h00);
        else chk(rdata, expq.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        {rst, wr, rd, hold, rdrv, rval, pa4} = '0;
        {t0o, t0e, t1o, t1e, addr, wdata} = '0;
        {pdout, pdir, ppull} = '0;
        void'($urandom(68073));
        do_reset(1'b1);
        chk(bg, 1'b1);
        do_reset(1'b0);
        chk(bg, 1'b0);
        chk(dpu, 1'b1);
        chk(poe, 8'h00);
        chk(ppl, 8'h00);
        chk({rpu, ext_req}, 2'b00);
        rd_reg(ADDR_SYSOPT, SYSOPT_RESET);
        @(posedge clk) {rdrv, rval} <= 2'b11;
        wait_n(4);
        chk(pa5, 1'b1);
        @(posedge clk) rval <= 1'b0;
        wait_n(4);
        chk({pa5, ext_req}, 2'b00);
        // board keeps driving high: an unpulled pin wanders and would
        // fake a reset request once the reset role is switched on
        @(posedge clk) rval <= 1'b1;
        send_bit(1'b1, 4);
        send_bit(1'b0, 13);
        wr_reg(ADDR_SYSOPT, 8'h03);
        wait_n(2);
        chk({rpu, ext_req, pa5}, 3'b100);
        wr_reg(ADDR_SYSOPT, 8'h02);
        rd_reg(ADDR_SYSOPT, 8'h03);
        @(posedge clk) {rdrv, rval} <= 2'b10;
        wait_n(4);
        chk(ext_req, 1'b1);
        @(posedge clk) rdrv <= 1'b0;
        wait_n(4);
        chk({ext_req, rpu}, 2'b01);
        rd_reg(ADDR_STATUS, 8'h05);
        rd_reg(ADDR_DBGTX, 8'h00);
        @(posedge clk) pa4 <= 1'($urandom);
        wr_reg(ADDR_SYSOPT, 8'h01);
        wait_n(2);
        chk({doe, dout}, {1'b1, pa4});
        @(posedge clk) {t0o, t1o} <= 2'($urandom);
        {t0e, t1e} <= 2'b11;
        pdout <= 8'($urandom);
        wait_n(2);
        chk({poe[5:4], pout[5:4]}, {2'b11, t1o, t0o});
        wr_reg(ADDR_PINSEL, 8'h01);
        wait_n(2);
        chk({poe[1:0], pout[1:0]}, {2'b11, t1o, t0o});
        chk(poe[5:4], 2'b00);
        test_done();
    end
endmodule : reset_debug_pin_mux_tb
`default_nettype wire
